// ### src/sfq_pkg.sv
// Constants shared by the serial frame qualifier
package sfq_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_BITS   = 32;
  localparam int unsigned DIR_POS      = 31;
  localparam int unsigned ADDR_MSB     = 30;
  localparam int unsigned ADDR_LSB     = 23;
  localparam int unsigned ACODE_MSB    = 22;
  localparam int unsigned ACODE_LSB    = 20;
  localparam int unsigned DIN_MSB      = 19;
  localparam int unsigned DIN_LSB      = 4;
  localparam int unsigned DREP_POS     = 3;
  localparam int unsigned DCODE_MSB    = 2;
  localparam int unsigned DCODE_LSB    = 0;
  localparam logic [3:0]  READ_FILL    = 4'hf;

  // ----------------------------------------------------------------
  // Status field bit positions and check code
  // ----------------------------------------------------------------
  localparam int unsigned STAT_CRC     = 4;
  localparam int unsigned STAT_RW      = 3;
  localparam int unsigned STAT_TO      = 2;
  localparam int unsigned STAT_CLK     = 1;
  localparam int unsigned STAT_ALERT   = 0;
  localparam int unsigned FLAG_CRC     = 3;
  localparam int unsigned FLAG_RW      = 2;
  localparam int unsigned FLAG_TO      = 1;
  localparam int unsigned FLAG_CLK     = 0;
  localparam logic [3:0]  FLAGS_RESET  = 4'h0;
  // Implicit +1 notation; feedback taps are the low bits plus one
  localparam logic [3:0]  CODE_POLY    = 4'h5;
  localparam logic [2:0]  CODE_TAPS    = {CODE_POLY[1:0], 1'b1};

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned TIMEOUT_NS   = 100000;
  localparam int unsigned TIMEOUT_CYC  = TIMEOUT_NS * CLK_MHZ / 1000;
  localparam int unsigned FIFO_DEPTH   = 4;

endpackage

// ### src/sfq_top.sv
// Serial frame qualifier with its write command FIFO
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Write command FIFO
// ------------------------------------------------------------------
module sfq_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = sfq_pkg::FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("sfq_fifo: depth must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } sfq_fifo_st_t;

  sfq_fifo_st_t q;
  sfq_fifo_st_t d;
  logic         push;
  logic         pop;

  assign in_ready_o  = (q.cnt != CW'(DEPTH));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o  = q.mem[q.rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp        = q.wp + PW'(1);
    end
    if (pop) begin
      d.rp = q.rp + PW'(1);
    end
    if (push && !pop) begin
      d.cnt = q.cnt + CW'(1);
    end else if (pop && !push) begin
      d.cnt = q.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ------------------------------------------------------------------
// Frame qualifier
// ------------------------------------------------------------------
module sfq_top #(
  parameter int unsigned TIMEOUT_CYCLES = sfq_pkg::TIMEOUT_CYC,
  parameter int unsigned FIFO_DEPTH     = sfq_pkg::FIFO_DEPTH
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        sclk_i,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  input  wire logic        alert_i,
  input  wire logic [3:0]  err_clear_i,
  output logic      [3:0]  err_flags_o,
  output logic             packet_check_alert_o,
  output logic             interface_alert_o,
  output logic             serial_port_alert_o,
  output logic      [7:0]  rd_addr_o,
  output logic             rd_req_o,
  input  wire logic [15:0] rd_data_i,
  input  wire logic        rd_reserved_i,
  output logic             rd_commit_o,
  output logic             wr_valid_o,
  input  wire logic        wr_ready_i,
  output logic      [7:0]  wr_addr_o,
  output logic      [15:0] wr_data_o
);
  localparam int unsigned TW = $clog2(TIMEOUT_CYCLES + 1);

  generate
    if (TIMEOUT_CYCLES < 1) begin : g_bad
      $error("sfq_top: timeout must be at least one cycle");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SFQ_IDLE  = 2'b01,
    SFQ_FRAME = 2'b10
  } sfq_state_t;

  typedef struct packed {
    sfq_state_t  state;
    logic        cs_s1;
    logic        cs_s2;
    logic        sclk_s1;
    logic        sclk_s2;
    logic        sclk_prev;
    logic        sdi_s1;
    logic        sdi_s2;
    logic [5:0]  cnt;
    logic        seen_rise;
    logic [31:0] rx;
    logic [4:0]  stat;
    logic [3:0]  flags;
    logic [TW-1:0] tmo;
    logic        rd_wait;
    logic [15:0] dout;
    logic        sdo;
    logic        sdo_oe;
    logic [7:0]  rd_addr;
    logic        rd_req;
    logic        rd_commit;
    logic        pca;
    logic        ifa;
    logic        spa;
  } sfq_st_t;

  sfq_st_t     q;
  sfq_st_t     d;
  logic        push_valid;
  logic        push_ready;
  logic [23:0] push_data;
  logic [23:0] pop_data;

  // ----------------------------------------------------------------
  // Check code
  // ----------------------------------------------------------------
  // MSB-first, all-zero start; leading zero pad leaves the remainder unchanged
  function automatic logic [2:0] sfq_code(input logic [15:0] bits);
    logic [2:0] rem;
    logic       fb;
    rem = 3'h0;
    for (int i = 15; i >= 0; i--) begin
      fb  = rem[2] ^ bits[i];
      rem = {rem[1:0], 1'b0} ^ (fb ? sfq_pkg::CODE_TAPS : 3'h0);
    end
    return rem;
  endfunction

  // ----------------------------------------------------------------
  // Field decode and qualification
  // ----------------------------------------------------------------
  logic        dir;
  logic [7:0]  addr;
  logic [15:0] din;
  logic        acode_ok;
  logic        dcode_ok;
  logic        dir_ok;
  logic        din_ok;
  logic        len_ok;
  logic        tmo_hit;
  logic        qualified;
  logic [31:0] out_word;
  logic        rise;
  logic        fall;
  logic [4:0]  rx_idx;
  logic [4:0]  tx_idx;

  assign dir      = q.rx[sfq_pkg::DIR_POS];
  assign addr     = q.rx[sfq_pkg::ADDR_MSB:sfq_pkg::ADDR_LSB];
  assign din      = q.rx[sfq_pkg::DIN_MSB:sfq_pkg::DIN_LSB];
  assign acode_ok = sfq_code({7'h0, dir, addr}) ==
                    q.rx[sfq_pkg::ACODE_MSB:sfq_pkg::ACODE_LSB];
  assign dcode_ok = sfq_code(din) ==
                    q.rx[sfq_pkg::DCODE_MSB:sfq_pkg::DCODE_LSB];
  assign dir_ok   = dir == q.rx[sfq_pkg::DREP_POS];
  assign din_ok   = !dir || (din == 16'h0);
  assign len_ok   = q.cnt == 6'(sfq_pkg::FRAME_BITS);
  assign tmo_hit  = q.tmo == TW'(TIMEOUT_CYCLES);
  assign qualified = len_ok && acode_ok && dcode_ok && dir_ok && din_ok && !tmo_hit;

  // ----------------------------------------------------------------
  // Output word
  // ----------------------------------------------------------------
  // Output frame is rebuilt each cycle; echo fields are sent well after arrival
  always_comb begin
    if (dir) begin
      out_word = {q.stat, sfq_code({11'h0, q.stat}), sfq_pkg::READ_FILL, q.dout,
                  acode_ok, sfq_code(q.dout)};
    end else begin
      out_word = {q.stat, sfq_code({11'h0, q.stat}), addr, din};
    end
  end

  // ----------------------------------------------------------------
  // Link edges and frame sequencing
  // ----------------------------------------------------------------
  assign rise   = q.sclk_s2 & ~q.sclk_prev;
  assign fall   = ~q.sclk_s2 & q.sclk_prev;
  assign rx_idx = 5'(5'h1f - q.cnt[4:0]);
  assign tx_idx = 5'(5'h1f - q.cnt[4:0]);

  always_comb begin
    d           = q;
    d.cs_s1     = chip_select_n_i;
    d.cs_s2     = q.cs_s1;
    d.sclk_s1   = sclk_i;
    d.sclk_s2   = q.sclk_s1;
    d.sclk_prev = q.sclk_s2;
    d.sdi_s1    = sdi_i;
    d.sdi_s2    = q.sdi_s1;
    d.rd_req    = 1'b0;
    d.rd_commit = 1'b0;
    d.pca       = 1'b0;
    d.ifa       = 1'b0;
    d.spa       = 1'b0;
    push_valid  = 1'b0;
    d.flags     = q.flags & ~err_clear_i;
    case (q.state)
      SFQ_IDLE: begin
        d.sdo_oe = 1'b0;
        d.sdo    = 1'b0;
        if (!q.cs_s2) begin
          d.state     = SFQ_FRAME;
          d.cnt       = 6'h0;
          d.seen_rise = 1'b0;
          d.rx        = 32'h0;
          d.tmo       = '0;
          d.dout      = 16'h0;
          d.rd_wait   = 1'b0;
          // Status snapshot taken at frame start, reported in every frame
          d.stat      = {q.flags, alert_i};
          d.sdo_oe    = 1'b1;
          d.sdo       = q.flags[sfq_pkg::FLAG_CRC];
        end
      end
      SFQ_FRAME: begin
        if (!tmo_hit) begin
          d.tmo = q.tmo + TW'(1);
        end
        if (rise) begin
          d.seen_rise = 1'b1;
          if (q.cnt < 6'(sfq_pkg::FRAME_BITS)) begin
            d.rx[rx_idx] = q.sdi_s2;
          end
          // Excess bits are dropped; count saturates one past a full frame
          if (q.cnt <= 6'(sfq_pkg::FRAME_BITS)) begin
            d.cnt = q.cnt + 6'h1;
          end
        end
        // Modes 0 and 3: ignore a leading fall before the first rise
        if (fall && q.seen_rise) begin
          if (q.cnt < 6'(sfq_pkg::FRAME_BITS)) begin
            d.sdo = out_word[tx_idx];
          end else begin
            d.sdo = 1'b0;
          end
        end
        // Address complete after nine bits: fetch read data early
        if (rise && q.cnt == 6'h8) begin
          d.rd_addr = {q.rx[30:24], q.sdi_s2};
          d.rd_req  = 1'b1;
          d.rd_wait = 1'b1;
        end
        if (q.rd_wait && !q.rd_req) begin
          d.rd_wait = 1'b0;
          d.dout    = rd_reserved_i ? 16'h0 : rd_data_i;
        end
        if (q.cs_s2) begin
          d.state  = SFQ_IDLE;
          d.sdo_oe = 1'b0;
          d.sdo    = 1'b0;
          if (qualified) begin
            if (dir) begin
              d.rd_commit = 1'b1;
            end else begin
              push_valid = 1'b1;
              // Full command queue counts as a failed internal transfer
              if (!push_ready) begin
                d.flags[sfq_pkg::FLAG_CLK] = 1'b1;
                d.ifa = 1'b1;
                d.spa = 1'b1;
              end
            end
          end else begin
            if (!len_ok) begin
              d.flags[sfq_pkg::FLAG_CLK] = 1'b1;
              d.ifa = 1'b1;
              d.spa = 1'b1;
            end else begin
              if (!acode_ok || !dcode_ok) begin
                d.flags[sfq_pkg::FLAG_CRC] = 1'b1;
                d.pca = 1'b1;
              end
              if (!dir_ok || !din_ok) begin
                d.flags[sfq_pkg::FLAG_RW] = 1'b1;
                d.ifa = 1'b1;
                d.spa = 1'b1;
              end
            end
            if (tmo_hit) begin
              d.flags[sfq_pkg::FLAG_TO] = 1'b1;
              d.ifa = 1'b1;
              d.spa = 1'b1;
            end
          end
        end
      end
      default: begin
        d.state = SFQ_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register and command queue
  // ----------------------------------------------------------------
  assign push_data = {addr, din};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q         <= '0;
      q.state   <= SFQ_IDLE;
      q.cs_s1   <= 1'b1;
      q.cs_s2   <= 1'b1;
      q.flags   <= sfq_pkg::FLAGS_RESET;
    end else begin
      q <= d;
    end
  end

  sfq_fifo #(
    .WIDTH (24),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_data),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  (pop_data)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wr_addr_o            = pop_data[23:16];
  assign wr_data_o            = pop_data[15:0];
  assign sdo_o                = q.sdo;
  assign sdo_oe_o             = q.sdo_oe;
  assign err_flags_o          = q.flags;
  assign packet_check_alert_o = q.pca;
  assign interface_alert_o    = q.ifa;
  assign serial_port_alert_o  = q.spa;
  assign rd_addr_o            = q.rd_addr;
  assign rd_req_o             = q.rd_req;
  assign rd_commit_o          = q.rd_commit;
endmodule

// ### verification/sfq_top_sva.sv
// Assertion checker for the serial frame qualifier ports
`timescale 1ns/1ps
module sfq_top_sva (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       chip_select_n_i,
  input wire logic       sdo_o,
  input wire logic       sdo_oe_o,
  input wire logic [3:0] err_clear_i,
  input wire logic [3:0] err_flags_o,
  input wire logic       packet_check_alert_o,
  input wire logic       interface_alert_o,
  input wire logic       serial_port_alert_o,
  input wire logic       rd_commit_o,
  input wire logic       wr_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Two sync stages plus the output flop
  sequence s_sel;
    $fell(chip_select_n_i) ##1 !chip_select_n_i [*3];
  endsequence
  sequence s_rel;
    $rose(chip_select_n_i) ##1 chip_select_n_i [*3];
  endsequence
  a_first_bit: assert property (s_sel |-> sdo_oe_o && sdo_o == err_flags_o[3])
    else $error("first status bit wrong");
  a_oe_off: assert property (s_rel |-> !sdo_oe_o)
    else $error("output enable stuck");
  a_quiet_line: assert property (!sdo_oe_o |-> !sdo_o)
    else $error("data while not driving");
  a_alerts_pair: assert property (interface_alert_o == serial_port_alert_o)
    else $error("alert pair split");
  a_crc_flag: assert property (packet_check_alert_o |-> err_flags_o[3])
    else $error("code flag missing");
  a_intf_flag: assert property (interface_alert_o |-> err_flags_o[2:0] != 3'h0)
    else $error("interface flag missing");
  a_exec_end: assert property ((packet_check_alert_o || rd_commit_o) |-> $fell(sdo_oe_o))
    else $error("action off frame end");
  a_no_exec: assert property ((packet_check_alert_o || interface_alert_o)
    |-> !rd_commit_o && !$rose(wr_valid_o))
    else $error("bad frame executed");
  a_flags_hold: assert property (($past(err_flags_o) & ~err_flags_o & ~$past(err_clear_i))
    == 4'h0)
    else $error("flag lost");
  a_flag_cause: assert property ((err_flags_o & ~$past(err_flags_o)) != 4'h0
    |-> packet_check_alert_o || interface_alert_o)
    else $error("flag set silently");
endmodule

bind sfq_top sfq_top_sva u_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .chip_select_n_i(chip_select_n_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
  .err_clear_i(err_clear_i), .err_flags_o(err_flags_o),
  .packet_check_alert_o(packet_check_alert_o), .interface_alert_o(interface_alert_o),
  .serial_port_alert_o(serial_port_alert_o), .rd_commit_o(rd_commit_o),
  .wr_valid_o(wr_valid_o));

// ### verification/sfq_host_model.sv
// Host master model driving the four-wire link
`timescale 1ns/1ps
module sfq_host_model (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      sdi_o
);
  logic sdo_line;
  // Released line floats; shown high so a late or missing enable is caught
  assign sdo_line = sdo_oe_i ? sdo_i : 1'b1;
  // Idle levels follow the pins' safety pull resistors
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o  = 1'b0;
  end
  // Output taken late in the high phase: the device answers a few clocks after the fall
  task automatic frame(input logic [31:0] di, input int nbits, input int hold_ns,
                       output logic [31:0] dout, output logic extra_nz);
    dout     = 32'h0;
    extra_nz = 1'b0;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    #32;
    for (int i = 0; i < nbits; i++) begin
      sdi_o = (i < 32) ? di[31-i] : i[0];
      #16;
      sclk_o = 1'b1;
      #12;
      if (i < 32) dout[31-i] = sdo_line;
      else extra_nz = extra_nz | sdo_line;
      #4;
      sclk_o = 1'b0;
    end
    #(16 + hold_ns);
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
    #16;
  endtask
endmodule

// ### verification/spi_frame_qualifier_tb_top.sv
// Self-checking bench for the serial frame qualifier
`timescale 1ns/1ps
module spi_frame_qualifier_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        alert = 1'b0;
  logic        wr_ready = 1'b0;
  logic        rd_rsv = 1'b0;
  logic [15:0] rd_data = 16'h0;
  logic [3:0]  clr = 4'h0;
  logic [3:0]  exp_flags = 4'h0;
  logic        cs_n, sclk, sdi, sdo, sdo_oe, pca, ia, spa, rd_req, rd_commit, wr_valid;
  logic [3:0]  flags;
  logic [7:0]  rd_addr, wr_addr;
  logic [15:0] wr_data;
  logic [23:0] wq[$];
  int          n_fail = 0;
  int          compares = 0;
  int          n_commit = 0;
  int          n_pca = 0;
  int          n_ia = 0;

  always #2 clk = ~clk;
  // Reserved places still return live data, so zeros must come from the block
  always @(negedge clk) begin
    rd_data <= {rd_addr, ~rd_addr};
    rd_rsv  <= rd_addr > 8'h98;
  end
  // Pulses stand between rising edges, so the falling edge sees each once
  always @(negedge clk) begin
    if (rd_commit === 1'b1) n_commit <= n_commit + 1;
    if (pca === 1'b1) n_pca <= n_pca + 1;
    if (ia === 1'b1 && spa === 1'b1) n_ia <= n_ia + 1;
  end

  sfq_top #(.TIMEOUT_CYCLES(400), .FIFO_DEPTH(4)) u_dut (
    .clk_i(clk), .rst_n_i(rst_n), .chip_select_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .alert_i(alert), .err_clear_i(clr), .err_flags_o(flags),
    .packet_check_alert_o(pca), .interface_alert_o(ia), .serial_port_alert_o(spa),
    .rd_addr_o(rd_addr), .rd_req_o(rd_req), .rd_data_i(rd_data), .rd_reserved_i(rd_rsv),
    .rd_commit_o(rd_commit), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data)
  );
  sfq_host_model u_host (.clk_i(clk), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .cs_n_o(cs_n),
                         .sclk_o(sclk), .sdi_o(sdi));

  function automatic logic [2:0] crc3(input logic [15:0] v, input int n);
    logic [2:0] r;
    logic       fb;
    r = 3'h0;
    for (int i = n - 1; i >= 0; i--) begin
      fb = v[i] ^ r[2];
      r = {r[1], r[0] ^ fb, fb};
    end
    return r;
  endfunction

  function automatic logic [31:0] mk(input logic rd, input logic [7:0] a, input logic [15:0] d);
    return {rd, a, crc3({7'h0, rd, a}, 9), d, rd, crc3(d, 16)};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic run(input logic [31:0] di, input int n, input int hold);
    logic [31:0] got, exp;
    logic [15:0] dv;
    logic [4:0]  st;
    logic [3:0]  nf;
    logic        xnz, rd, aok;
    int          c0, p0, i0;
    rd  = di[31];
    aok = crc3({7'h0, di[31:23]}, 9) === di[22:20];
    st  = {exp_flags, alert};
    dv  = (di[30:23] > 8'h98) ? 16'h0 : {di[30:23], ~di[30:23]};
    exp = rd ? {st, crc3(16'(st), 5), 4'hf, dv, aok, crc3(dv, 16)}
             : {st, crc3(16'(st), 5), di[30:23], di[19:4]};
    nf = {2'h0, hold > 0, n != 32};
    if (n == 32) begin
      nf[3] = !aok || crc3(di[19:4], 16) !== di[2:0];
      nf[2] = di[31] !== di[3] || (rd && di[19:4] !== 16'h0);
    end
    if (nf == 4'h0 && !rd) begin
      if (wq.size() == 4) nf[0] = 1'b1;
      else wq.push_back({di[30:23], di[19:4]});
    end
    c0 = n_commit;
    p0 = n_pca;
    i0 = n_ia;
    u_host.frame(di, n, hold, got, xnz);
    if (n >= 32) chk(got, exp);
    chk({31'h0, xnz}, 32'h0);
    repeat (8) @(negedge clk);
    exp_flags = exp_flags | nf;
    chk({28'h0, flags}, {28'h0, exp_flags});
    chk(32'(n_commit - c0), (nf == 4'h0 && rd) ? 32'h1 : 32'h0);
    chk(32'(n_pca - p0), {31'h0, nf[3]});
    chk(32'(n_ia - i0), {31'h0, nf[2:0] != 3'h0});
    chk({24'h0, rd_addr}, {24'h0, di[30:23]});
  endtask

  task automatic drain();
    logic [23:0] e;
    int          k;
    while (wq.size() > 0) begin
      e = wq.pop_front();
      k = 0;
      while (wr_valid !== 1'b1 && k < 50) begin
        @(negedge clk);
        k++;
      end
      if (k == 50) begin
        n_fail++;
        stop_test();
      end
      chk({8'h0, wr_addr, wr_data}, {8'h0, e});
      wr_ready = 1'b1;
      @(negedge clk);
      wr_ready = 1'b0;
      @(negedge clk);
    end
    @(negedge clk);
    chk({31'h0, wr_valid}, 32'h0);
  endtask

  task automatic clear();
    clr = 4'hf;
    @(negedge clk);
    clr = 4'h0;
    exp_flags = 4'h0;
    @(negedge clk);
    chk({28'h0, flags}, 32'h0);
  endtask

  task automatic sc_basic();
    run(mk(1'b0, 8'h12, 16'ha5c3), 32, 0);
    run(mk(1'b1, 8'h12, 16'h0), 32, 0);
    alert = 1'b1;
    run(mk(1'b1, 8'ha0, 16'h0), 32, 0);
    alert = 1'b0;
    drain();
  endtask

  task automatic sc_codes();
    run(mk(1'b0, 8'h34, 16'h1234) ^ 32'h0010_0000, 32, 0);
    run(mk(1'b1, 8'h34, 16'h0) ^ 32'h0010_0000, 32, 0);
    run(mk(1'b0, 8'h35, 16'hbeef) ^ 32'h1, 32, 0);
    drain();
    clear();
  endtask

  task automatic sc_errs();
    run(mk(1'b0, 8'h40, 16'h0f0f) ^ 32'h8, 32, 0);
    run(mk(1'b1, 8'h40, 16'h0001), 32, 0);
    run(mk(1'b0, 8'h50, 16'h5555), 34, 0);
    run(mk(1'b1, 8'h50, 16'h0), 33, 0);
    run(mk(1'b0, 8'h51, 16'h1111), 31, 0);
    run(mk(1'b0, 8'h60, 16'h2222), 32, 800);
    drain();
    clear();
  endtask

  task automatic sc_full();
    for (int i = 0; i < 5; i++) run(mk(1'b0, 8'h70 + 8'(i), 16'h0101 * 16'(i)), 32, 0);
    drain();
    clear();
  endtask

  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    sc_basic();
    sc_codes();
    sc_errs();
    sc_full();
    stop_test();
  end
endmodule
